// ==== twm_defines.svh ====
/*
 * register indices, field positions, reset values and code points of the
 * timer control block; assumes one include per compile unit
 */
`ifndef TWM_DEFINES_SVH
`define TWM_DEFINES_SVH

// register indices, byte address is four times the index
`define TWM_IDX_CTRL_A 10'h000
`define TWM_IDX_CTRL_B 10'h001
`define TWM_IDX_LOCK 10'h004
`define TWM_IDX_VALID 10'h006
`define TWM_IDX_IRQ_MASK 10'h00A
`define TWM_IDX_IRQ_STAT 10'h00B
`define TWM_IDX_COUNT 10'h020
`define TWM_IDX_CYCLE 10'h026
`define TWM_IDX_COMPARE_ZERO_BUF 10'h038
`define TWM_IDX_CMP1_BUF 10'h03A
`define TWM_IDX_CMP2_BUF 10'h03C

// reset values
`define TWM_RST_CTRL 8'h00
`define TWM_RST_CYCLE 16'hFFFF
`define TWM_RST_WORD 16'h0000

// waveform mode codes
`define TWM_MODE_NORMAL 3'h0
`define TWM_MODE_FREQ 3'h1
`define TWM_MODE_ONE_SLOPE 3'h3
`define TWM_MODE_DUAL_TOP 3'h5

// interrupt status bit positions
`define TWM_IRQ_OVF 0
`define TWM_IRQ_UPD 1

// prescaler width, divide by 1024 at most
`define TWM_PRESC_W 10

`endif

// ==== twm_pkg.sv ====
/*
 * types of the timer control block: register field layouts
 * assumes twm_defines.svh for the numeric constants
 */
package twm_pkg;

  // control register a layout
  typedef struct packed {
    logic [3:0] rsv;
    logic [2:0] prescale_select;
    logic enable;
  } twm_ctrl_a_s;

  // control register b layout
  typedef struct packed {
    logic rsv;
    logic [2:0] channel_output_enable;
    logic auto_lock_update;
    logic [2:0] waveform_mode_select;
  } twm_ctrl_b_s;

endpackage : twm_pkg

// ==== twm_timer_ctrl.sv ====
/*
 * control part of a 16-bit timer: prescaler, enable, waveform mode,
 * compare buffering with update lock, pin override, apb register slave
 * assumes an apb3 master on CLK_SYS_I and synchronous port inputs
 */
// Functional notes
// - prescaler codes divide by 1 to 1024
// - counter runs only while enable bit set
// - output enable bit overrides port pin setting outside normal and reserved modes
// - auto-lock holds lock until enabled buffers valid
// - with auto-lock, lock stays clear until update, then set
// - without auto-lock, only software changes lock
// - normal mode produces no waveform output
// - frequency, single- and dual-slope modes route generator when enabled
// - three-bit field selects the waveform mode
// - mode sets top, update and overflow points
// - lock set skips buffer transfer at update
// - buffer write sets valid, buffer transfer clears it
`timescale 1ns/1ps
`include "twm_defines.svh"

module twm_timer_ctrl (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [2:0] PORT_OUT_I,
  output logic [2:0] WAVE_PIN_O,
  output logic IRQ_O
);

  twm_pkg::twm_ctrl_a_s ctrl_a;
  twm_pkg::twm_ctrl_b_s ctrl_b;
  logic update_lock;
  logic auto_lock_update_q;
  logic [2:0] buffer_valid_flag;
  logic [15:0] compare_buffer [3];
  logic [15:0] compare_reg [3];
  logic [15:0] cycle_length_register;
  logic [15:0] count;
  logic count_down;
  logic [`TWM_PRESC_W-1:0] presc;
  logic [2:0] wave;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;

  // apb decode
  wire [9:0] idx = PADDR_I[11:2];
  wire setup = CE_I & PSEL_I & ~PENABLE_I;
  wire wr = CE_I & PSEL_I & PENABLE_I & PWRITE_I;
  wire hit_a = idx == `TWM_IDX_CTRL_A;
  wire hit_b = idx == `TWM_IDX_CTRL_B;
  wire hit_lock = idx == `TWM_IDX_LOCK;
  wire hit_valid = idx == `TWM_IDX_VALID;
  wire hit_mask = idx == `TWM_IDX_IRQ_MASK;
  wire hit_stat = idx == `TWM_IDX_IRQ_STAT;
  wire hit_count = idx == `TWM_IDX_COUNT;
  wire hit_cycle = idx == `TWM_IDX_CYCLE;
  wire [2:0] hit_buf = {idx == `TWM_IDX_CMP2_BUF,
                        idx == `TWM_IDX_CMP1_BUF,
                        idx == `TWM_IDX_COMPARE_ZERO_BUF};
  wire mapped = hit_a | hit_b | hit_lock | hit_valid | hit_mask
              | hit_stat | hit_count | hit_cycle | (|hit_buf);
  wire [2:0] buf_wr = {3{wr}} & hit_buf;

  // apb handshake, stalls while the block is frozen
  assign PREADY_O = CE_I;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

  // read data selection
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_a) next_rdata[7:0] = ctrl_a;
    if (hit_b) next_rdata[7:0] = ctrl_b;
    if (hit_lock) next_rdata[1] = update_lock;
    if (hit_valid) next_rdata[3:1] = buffer_valid_flag;
    if (hit_mask) next_rdata[1:0] = irq_mask;
    if (hit_stat) next_rdata[1:0] = irq_stat;
    if (hit_count) next_rdata[15:0] = count;
    if (hit_cycle) next_rdata[15:0] = cycle_length_register;
    for (int n = 0; n < 3; n++) begin
      if (hit_buf[n]) next_rdata[15:0] = compare_buffer[n];
    end
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) PRDATA_O <= 32'h0000_0000;
    else if (setup) PRDATA_O <= next_rdata;
  end

  // mode decode
  wire [2:0] mode = ctrl_b.waveform_mode_select;
  wire is_normal = mode == `TWM_MODE_NORMAL;
  wire is_freq = mode == `TWM_MODE_FREQ;
  wire is_one = mode == `TWM_MODE_ONE_SLOPE;
  wire is_dual = mode == `TWM_MODE_DUAL_TOP;
  wire mode_ok = is_normal | is_freq | is_one | is_dual;

  // prescaler tap mask per code
  logic [`TWM_PRESC_W-1:0] presc_mask;
  always_comb begin
    case (ctrl_a.prescale_select)
      3'h0: presc_mask = 10'h000;
      3'h1: presc_mask = 10'h001;
      3'h2: presc_mask = 10'h003;
      3'h3: presc_mask = 10'h007;
      3'h4: presc_mask = 10'h00F;
      3'h5: presc_mask = 10'h03F;
      3'h6: presc_mask = 10'h0FF;
      3'h7: presc_mask = 10'h3FF;
      default: presc_mask = 10'h000;
    endcase
  end
  wire run = CE_I & ctrl_a.enable;
  wire tick = run & ((presc & presc_mask) == presc_mask);

  // top, update and overflow points per mode
  wire [15:0] top = is_freq ? compare_reg[0] : cycle_length_register;
  wire at_top = count == top;
  wire at_bot = count == 16'h0000;
  wire upd_evt = tick & mode_ok & ((is_normal | is_freq) ? at_top
               : is_one ? at_bot : (count_down & at_bot));
  wire ovf_evt = tick & mode_ok & ((is_normal | is_freq) ? at_top
               : is_one ? at_bot : (~count_down & at_top));
  wire transfer = upd_evt & ~update_lock;

  // enabled channels whose buffers are all written
  wire [2:0] en = ctrl_b.channel_output_enable;
  wire all_valid = &(buffer_valid_flag | ~en);

  // prescaler and counter
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      presc <= '0;
      count <= `TWM_RST_WORD;
      count_down <= 1'b0;
    end else if (run) begin
      presc <= presc + 10'h001;
      if (tick) begin
        if (is_dual) begin
          if (~count_down & at_top) count_down <= 1'b1;
          else if (count_down & at_bot) count_down <= 1'b0;
          count <= (count_down & ~at_bot) | (~count_down & at_top)
                 ? count - 16'h0001 : count + 16'h0001;
        end else begin
          count_down <= 1'b0;
          count <= at_top ? 16'h0000 : count + 16'h0001;
        end
      end
    end
  end

  // control registers and period
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ctrl_a <= `TWM_RST_CTRL;
      ctrl_b <= `TWM_RST_CTRL;
      cycle_length_register <= `TWM_RST_CYCLE;
      irq_mask <= 2'h0;
      auto_lock_update_q <= 1'b0;
    end else if (CE_I) begin
      auto_lock_update_q <= ctrl_b.auto_lock_update;
      if (wr & hit_a) ctrl_a <= PWDATA_I[7:0];
      if (wr & hit_b) ctrl_b <= PWDATA_I[7:0];
      if (wr & hit_cycle) cycle_length_register <= PWDATA_I[15:0];
      if (wr & hit_mask) irq_mask <= PWDATA_I[1:0];
    end
  end

  // update lock: software owns it unless auto-lock is on
  logic next_lock;
  always_comb begin
    next_lock = update_lock;
    if (wr & hit_lock) next_lock = PWDATA_I[1];
    if (ctrl_b.auto_lock_update) begin
      if (~auto_lock_update_q) next_lock = 1'b1;
      else if (transfer) next_lock = 1'b1;
      else if (update_lock & all_valid) next_lock = 1'b0;
      // hold either state, software writes do not reach the lock here
      else next_lock = update_lock;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) update_lock <= 1'b0;
    else if (CE_I) update_lock <= next_lock;
  end

  // per-channel buffer, valid flag, compare register and generator
  for (genvar n = 0; n < 3; n++) begin : g_ch
    always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
        compare_buffer[n] <= `TWM_RST_WORD;
        compare_reg[n] <= `TWM_RST_WORD;
        buffer_valid_flag[n] <= 1'b0;
      end else if (CE_I) begin
        if (buf_wr[n]) compare_buffer[n] <= PWDATA_I[15:0];
        if (transfer) compare_reg[n] <= compare_buffer[n];
        buffer_valid_flag[n] <= buf_wr[n] | (buffer_valid_flag[n]
                                & ~transfer);
      end
    end

    // generator: toggle on match in frequency mode, compare level in pwm
    always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) wave[n] <= 1'b0;
      else if (run & tick) begin
        if (is_freq) wave[n] <= wave[n] ^ (count == compare_reg[n]);
        else wave[n] <= count < compare_reg[n];
      end
    end

    // pin: generator only outside normal and reserved modes and when enabled
    wire route = ~is_normal & mode_ok & en[n];
    always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) WAVE_PIN_O[n] <= 1'b0;
      else if (CE_I) WAVE_PIN_O[n] <= route ? wave[n] : PORT_OUT_I[n];
    end
  end

  // sticky interrupt status, write one to clear, a new event wins
  logic [1:0] evt;
  assign evt[`TWM_IRQ_OVF] = ovf_evt;
  assign evt[`TWM_IRQ_UPD] = transfer;
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) irq_stat <= 2'h0;
    else if (CE_I) irq_stat <= evt | (irq_stat
                               & ~({2{wr & hit_stat}} & PWDATA_I[1:0]));
  end

  assign IRQ_O = |(irq_stat & irq_mask);

endmodule : twm_timer_ctrl

// ==== twm_timer_ctrl_properties.sv ====
/* port checker of the timer control block, bound to twm_timer_ctrl;
   assumes CLK_SYS_I rising edge and synchronous SRST_I */
`timescale 1ns/1ps
`include "twm_defines.svh"
module twm_props (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [2:0] PORT_OUT_I,
  input wire logic [2:0] WAVE_PIN_O,
  input wire logic IRQ_O
);
  logic [7:0] cb;
  logic [1:0] mk;
  wire wr = PSEL_I && PENABLE_I && PWRITE_I && CE_I;
  // shadows of control b and interrupt mask
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      cb <= 8'h00;
      mk <= 2'h0;
    end else if (wr && PADDR_I[11:2] == `TWM_IDX_CTRL_B) begin
      cb <= PWDATA_I[7:0];
    end else if (wr && PADDR_I[11:2] == `TWM_IDX_IRQ_MASK) begin
      mk <= PWDATA_I[1:0];
    end
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  sequence s_acc;
    PSEL_I && PENABLE_I && CE_I;
  endsequence
  property p_rdy; PREADY_O == CE_I; endproperty
  property p_err; PSLVERR_O |-> PSEL_I && PENABLE_I; endproperty
  property p_unm; s_acc ##0 (PSLVERR_O && !PWRITE_I) |-> PRDATA_O == 32'h0;
  endproperty
  property p_hold; s_acc ##1 !PSEL_I |-> $stable(PRDATA_O); endproperty
  property p_irq; mk == 2'h0 |-> !IRQ_O; endproperty
  property p_norm;
    CE_I && cb[2:0] == 3'h0 |=> WAVE_PIN_O == $past(PORT_OUT_I);
  endproperty
  property p_off;
    CE_I && cb[6:4] == 3'h0 |=> WAVE_PIN_O == $past(PORT_OUT_I);
  endproperty
  property p_rsv; CE_I && (cb[2:0] == 3'h2 || cb[2:0] == 3'h4)
    |=> WAVE_PIN_O == $past(PORT_OUT_I); endproperty
  a_rdy: assert property (p_rdy) else $error("ready differs");
  a_err: assert property (p_err) else $error("error outside access");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_irq: assert property (p_irq) else $error("irq while masked");
  a_norm: assert property (p_norm) else $error("normal mode drove pin");
  a_off: assert property (p_off) else $error("disabled pin driven");
  a_rsv: assert property (p_rsv) else $error("reserved drove pin");
endmodule : twm_props
bind twm_timer_ctrl twm_props i_props (.CLK_SYS_I, .SRST_I, .CE_I, .PSEL_I,
  .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O,
  .PSLVERR_O, .PORT_OUT_I, .WAVE_PIN_O, .IRQ_O);

// ==== twm_timer_ctrl_bench.sv ====
/* self-checking bench of the timer control block over apb;
   assumes twm_defines.svh and the bound port checker */
`timescale 1ns/1ps
`include "twm_defines.svh"
module twm_timer_ctrl_bench;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, psel = 1'b0, pen = 1'b0;
  logic pwr = 1'b0, e;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0, rd, c0;
  logic [2:0] port = 3'h0;
  logic [9:0] ri [8] = '{10'h000, 10'h001, 10'h004, 10'h006, 10'h00A,
    10'h00B, 10'h020, 10'h026};
  wire [31:0] prd;
  wire [2:0] pin;
  wire rdy, err, irq;
  int errors = 0, compares = 0;
  twm_timer_ctrl i_dut (.CLK_SYS_I(clk), .SRST_I(srst), .CE_I(ce),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr),
    .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
    .PORT_OUT_I(port), .WAVE_PIN_O(pin), .IRQ_O(irq));
  // clock of 40 ns
  always #20 clk = ~clk;
  task automatic conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, waits for ready under a bound
  task automatic apb(input logic w, input logic [9:0] ix,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= {ix, 2'h0};
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        conclude();
      end
      @(posedge clk);
    end
    rd = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [9:0] ix, input logic [31:0] x);
    apb(1'b0, ix, 32'h0);
    chk(rd, x);
  endtask : rdc
  // count advance over 2048 cycles for a control a value
  task automatic cnt(input logic [31:0] a, input logic [31:0] x);
    apb(1'b1, `TWM_IDX_CTRL_A, a);
    apb(1'b0, `TWM_IDX_COUNT, 32'h0);
    c0 = rd;
    repeat (2045) @(posedge clk);
    apb(1'b0, `TWM_IDX_COUNT, 32'h0);
    chk((rd - c0) & 32'hFFFF, x);
  endtask : cnt
  function automatic int dsh(input int c);
    return c < 4 ? c : 2 * c - 4;
  endfunction : dsh
  // channels that must show the port value
  function automatic logic [2:0] pm(input logic [7:0] b);
    return (b[2:0] == 3'h1 || b[2:0] == 3'h3 || b[2:0] == 3'h5) ?
      ~b[6:4] : 3'h7;
  endfunction : pm
  // main sequence
  initial begin
    logic [31:0] a;
    void'($urandom(32'h6cde78b7));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    foreach (ri[k]) rdc(ri[k], k == 7 ? 32'hFFFF : 32'h0);
    apb(1'b1, 10'h3FF, $urandom);
    rdc(10'h3FF, 32'h0);
    chk(32'(e), 32'h1);
    a = $urandom & 32'hE;
    apb(1'b1, `TWM_IDX_CTRL_A, a);
    rdc(`TWM_IDX_CTRL_A, a);
    $display("test registers done");
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, `TWM_IDX_CTRL_B, 32'h70 | m);
      rdc(`TWM_IDX_CTRL_B, 32'h70 | m);
      port <= 3'($urandom);
      repeat (2) @(posedge clk);
      chk(32'(pin & pm(8'h70 | m)), 32'(port & pm(8'h70 | m)));
      chk(32'(pin & ~pm(8'h70 | m)), 32'h0);
    end
    $display("test pins done");
    apb(1'b1, `TWM_IDX_CTRL_B, 32'h0);
    apb(1'b1, `TWM_IDX_CYCLE, 32'h4);
    apb(1'b1, `TWM_IDX_LOCK, 32'h2);
    apb(1'b1, `TWM_IDX_IRQ_MASK, 32'h2);
    apb(1'b1, `TWM_IDX_COMPARE_ZERO_BUF, $urandom & 32'hFFFF);
    rdc(`TWM_IDX_VALID, 32'h2);
    apb(1'b1, `TWM_IDX_CTRL_A, 32'h1);
    repeat (20) @(posedge clk);
    rdc(`TWM_IDX_VALID, 32'h2);
    rdc(`TWM_IDX_LOCK, 32'h2);
    chk(32'(irq), 32'h0);
    rdc(`TWM_IDX_IRQ_STAT, 32'h1);
    apb(1'b1, `TWM_IDX_LOCK, 32'h0);
    repeat (20) @(posedge clk);
    rdc(`TWM_IDX_VALID, 32'h0);
    rdc(`TWM_IDX_LOCK, 32'h0);
    chk(32'(irq), 32'h1);
    rdc(`TWM_IDX_IRQ_STAT, 32'h3);
    $display("test lock done");
    apb(1'b1, `TWM_IDX_CTRL_B, 32'h18);
    apb(1'b1, `TWM_IDX_IRQ_STAT, 32'h3);
    repeat (20) @(posedge clk);
    rdc(`TWM_IDX_LOCK, 32'h2);
    chk(32'(irq), 32'h0);
    apb(1'b1, `TWM_IDX_COMPARE_ZERO_BUF, $urandom & 32'hFFFF);
    repeat (20) @(posedge clk);
    rdc(`TWM_IDX_LOCK, 32'h2);
    rdc(`TWM_IDX_VALID, 32'h0);
    chk(32'(irq), 32'h1);
    $display("test auto lock done");
    // dual slope over a period of 4: eight ticks a round, 2048 ticks return
    apb(1'b1, `TWM_IDX_CTRL_B, 32'h5);
    cnt(32'h1, 32'h0);
    $display("test dual slope done");
    apb(1'b1, `TWM_IDX_CTRL_B, 32'h0);
    apb(1'b1, `TWM_IDX_CYCLE, 32'hFFFF);
    for (int c = 0; c < 8; c++) cnt(32'(c * 2 + 1), 32'(2048 >> dsh(c)));
    // clock enable low for 1000 of the 2048 edges freezes the counter
    apb(1'b1, `TWM_IDX_CTRL_A, 32'h1);
    apb(1'b0, `TWM_IDX_COUNT, 32'h0);
    c0 = rd;
    ce <= 1'b0;
    repeat (1000) @(posedge clk);
    ce <= 1'b1;
    repeat (1045) @(posedge clk);
    apb(1'b0, `TWM_IDX_COUNT, 32'h0);
    chk((rd - c0) & 32'hFFFF, 32'd1048);
    cnt(32'hE, 32'h0);
    $display("test prescaler done");
    conclude();
  end
endmodule : twm_timer_ctrl_bench
